// ### ucpsm_pkg.sv
// constants, types and register map of the usb clock and power state manager
// assumes a single 100 MHz clock and a plain word-wide register port
package ucpsm_pkg;

    // clock rate
    localparam int CLK_MHZ             = 100;

    // timing figures in their own units
    localparam int PRECHARGE_US        = 200;     // usb pll loop precharge
    localparam int USB_PLL_RESTART_US  = 35;      // usb pll restart
    localparam int XTAL_RESTART_MS     = 10;      // crystal restart
    localparam int SETTLE_NS           = 40;      // quiet time around a mux switch

    // derived cycle counts
    localparam int PRECHARGE_CYC       = PRECHARGE_US * CLK_MHZ;
    localparam int USB_PLL_RESTART_CYC = USB_PLL_RESTART_US * CLK_MHZ;
    localparam int XTAL_RESTART_CYC    = XTAL_RESTART_MS * 1000 * CLK_MHZ;
    localparam int SETTLE_CYC          = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W               = 20;

    // register port
    localparam int ADDR_W              = 8;
    localparam int DATA_W              = 32;
    localparam logic [ADDR_W-1:0] CTRL_OFS      = 8'h00;
    localparam logic [ADDR_W-1:0] WAKE_CFG_OFS  = 8'h04;
    localparam logic [ADDR_W-1:0] WAKE_EN_OFS   = 8'h08;
    localparam logic [ADDR_W-1:0] WAKE_STAT_OFS = 8'h0C;
    localparam logic [ADDR_W-1:0] STATUS_OFS    = 8'h10;

    // control register bits
    localparam int CTRL_USB_EN         = 0;       // controller enabled
    localparam int CTRL_LPM_PLL_STOP   = 1;       // stop usb pll in lpm sleep
    localparam int CTRL_XTAL_KEEP      = 2;       // keep crystal on when off

    // wake lines: 0 bus power, 1 minus line, 2 plus line
    localparam int NLINE               = 3;
    localparam int LINE_VBUS           = 0;
    localparam int LINE_DM             = 1;
    localparam int LINE_DP             = 2;
    localparam int FIELD_LSB [NLINE]   = '{12, 8, 4};
    localparam int CFG_W               = 16;
    localparam logic [CFG_W-1:0] WAKE_CFG_RST = 16'h0000;

    // detection codes
    localparam logic [3:0] DET_RISE    = 4'h8;
    localparam logic [3:0] DET_FALL    = 4'h9;
    localparam logic [3:0] DET_TOGGLE  = 4'hA;
    localparam logic [3:0] DET_HIGH    = 4'hB;
    localparam logic [3:0] DET_LOW     = 4'hC;

    // usb pll divider settings
    localparam logic [5:0] PLL_N_PRECHARGE = 6'h3F;
    localparam logic [5:0] PLL_N_TARGET    = 6'h0F;
    localparam logic [1:0] PLL_M_VALUE     = 2'h2;
    localparam logic [5:0] PLL_N_RST       = 6'h0F;

    // link power states
    typedef enum logic [1:0] {LINK_L0, LINK_L1, LINK_L2, LINK_L3} ucpsm_link_t;

    // clock sequencer states
    typedef enum logic [3:0] {
        SEQ_IDLE, SEQ_XTAL, SEQ_SYSTEM_PLL, SEQ_SYS32, SEQ_PRECH, SEQ_ULOCK,
        SEQ_GATE, SEQ_ON, SEQ_UNGATE, SEQ_SYS16, SEQ_PLLOFF
    } ucpsm_seq_t;

    // clock control outputs travelling together
    typedef struct packed {
        logic       xtal_en;        // high frequency crystal enable
        logic       sys_pll_en;     // system pll enable
        logic       sys_sel_32;     // 1: system clock 32 MHz, 0: 16 MHz
        logic       usb_pll_en;     // usb pll enable
        logic [5:0] usb_pll_n;      // usb pll n divider
        logic [1:0] usb_pll_m;      // usb pll m divider
        logic       ctl_clk_en;     // controller clock gate
        logic       phy_clk_en;     // phy clock gate
    } ucpsm_clk_t;

endpackage : ucpsm_pkg

// ### ucpsm_top.sv
// usb clock and power state manager: wake detector, link state tracking,
// and the sequencer that raises and lowers the usb and system clocks
// assumes glitch-free clock gate and mux cells downstream, analog lock
// flags on asynchronous pins, and controller event pulses on mclk
`timescale 1ns/1ps
module ucpsm_top #(
    parameter int PRECHARGE_CYCLES = ucpsm_pkg::PRECHARGE_CYC,
    parameter int XTAL_CYCLES      = ucpsm_pkg::XTAL_RESTART_CYC
) (
    input  wire logic                          mclk,
    input  wire logic                          resetn,
    input  wire logic [ucpsm_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [ucpsm_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output      logic [ucpsm_pkg::DATA_W-1:0]  reg_rdata,
    input  wire logic                          bus_power_sense,
    input  wire logic                          line_dp,
    input  wire logic                          line_dm,
    input  wire logic                          sys_pll_lock,
    input  wire logic                          usb_pll_lock,
    input  wire logic                          ctl_suspend_evt,
    input  wire logic                          link_power_ack_flag,
    output      logic                          wake_irq,
    output      ucpsm_pkg::ucpsm_clk_t         clk_ctl
);

    localparam int NSYNC = ucpsm_pkg::NLINE + 2;  // wake lines plus two lock flags
    localparam int CNT_W = ucpsm_pkg::CNT_W;      // wait counter width for casts

    // pins gathered for the synchroniser loop
    logic [NSYNC-1:0]             pin_in;
    logic [NSYNC-1:0]             sync1_r;       // first stage, read only by sync2
    logic [NSYNC-1:0]             sync2_r;       // second stage
    logic [NSYNC-1:0]             sync3_r;       // third stage
    logic [NSYNC-1:0]             stable_r;      // accepted level
    logic [NSYNC-1:0]             changed;       // accepted level changes now

    // registers
    logic [2:0]                   ctrl_r;        // control bits
    logic [ucpsm_pkg::CFG_W-1:0]  wake_cfg_r;    // detection codes
    logic [ucpsm_pkg::NLINE-1:0]  wake_en_r;     // per line enables
    logic [ucpsm_pkg::NLINE-1:0]  wake_stat_r;   // sticky detections
    logic [ucpsm_pkg::NLINE-1:0]  det_fire;      // enabled detection this cycle

    // state
    ucpsm_pkg::ucpsm_link_t       link_r;        // link power state
    ucpsm_pkg::ucpsm_seq_t        seq_r;         // clock sequencer
    logic [ucpsm_pkg::CNT_W-1:0]  cnt_r;         // sequencer wait counter
    logic                         lpm_off_r;     // shutdown was the lpm variant
    logic                         want_on;       // usb clocks wanted
    logic                         conn_evt;      // connection detected
    logic                         disc_evt;      // disconnection detected
    logic                         resume_evt;    // resume or bus reset detected

    assign pin_in = {usb_pll_lock, sys_pll_lock, line_dp, line_dm, bus_power_sense};

    // three stage synchroniser, level taken once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++)
        begin : g_sync
            always_ff @(posedge mclk or negedge resetn)
            begin
                if (!resetn)
                begin
                    sync1_r[gi]  <= 1'b0;
                    sync2_r[gi]  <= 1'b0;
                    sync3_r[gi]  <= 1'b0;
                    stable_r[gi] <= 1'b0;
                end
                else
                begin
                    sync1_r[gi] <= pin_in[gi];
                    sync2_r[gi] <= sync1_r[gi];
                    sync3_r[gi] <= sync2_r[gi];
                    if (sync2_r[gi] == sync3_r[gi])
                        stable_r[gi] <= sync3_r[gi];
                end
            end
            assign changed[gi] = (sync2_r[gi] == sync3_r[gi]) && (sync3_r[gi] != stable_r[gi]);
        end
    endgenerate

    // per line detector, code chosen by its config field
    generate
        for (gi = 0; gi < ucpsm_pkg::NLINE; gi++)
        begin : g_det
            logic [3:0] code;   // this line's detection code
            logic       hit;    // detection condition met
            assign code = wake_cfg_r[ucpsm_pkg::FIELD_LSB[gi] +: 4];
            always_comb
            begin
                unique case (code)
                    ucpsm_pkg::DET_RISE:   hit = changed[gi] && sync3_r[gi];
                    ucpsm_pkg::DET_FALL:   hit = changed[gi] && !sync3_r[gi];
                    ucpsm_pkg::DET_TOGGLE: hit = changed[gi];
                    ucpsm_pkg::DET_HIGH:   hit = stable_r[gi];
                    ucpsm_pkg::DET_LOW:    hit = !stable_r[gi];
                    default:               hit = 1'b0;
                endcase
            end
            assign det_fire[gi] = hit && wake_en_r[gi];
        end
    endgenerate

    // events that drive the link state
    assign conn_evt   = det_fire[ucpsm_pkg::LINE_VBUS] && stable_r[ucpsm_pkg::LINE_VBUS];
    assign disc_evt   = det_fire[ucpsm_pkg::LINE_VBUS] && !stable_r[ucpsm_pkg::LINE_VBUS];
    assign resume_evt = det_fire[ucpsm_pkg::LINE_DP] || det_fire[ucpsm_pkg::LINE_DM];

    // control register, reset with controller disabled
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            ctrl_r <= 3'h0;
        else if (reg_wr && reg_addr == ucpsm_pkg::CTRL_OFS)
            ctrl_r <= reg_wdata[2:0];
    end

    // wake configuration and enables
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            wake_cfg_r <= ucpsm_pkg::WAKE_CFG_RST;
            wake_en_r  <= '0;
        end
        else if (reg_wr)
        begin
            if (reg_addr == ucpsm_pkg::WAKE_CFG_OFS)
                wake_cfg_r <= reg_wdata[ucpsm_pkg::CFG_W-1:0];
            if (reg_addr == ucpsm_pkg::WAKE_EN_OFS)
                wake_en_r <= reg_wdata[ucpsm_pkg::NLINE-1:0];
        end
    end

    // sticky wake status, write one clears, a new detection wins
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            wake_stat_r <= '0;
        else if (reg_wr && reg_addr == ucpsm_pkg::WAKE_STAT_OFS)
            wake_stat_r <= (wake_stat_r & ~reg_wdata[ucpsm_pkg::NLINE-1:0]) | det_fire;
        else
            wake_stat_r <= wake_stat_r | det_fire;
    end

    // single wake interrupt from any recorded detection
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            wake_irq <= 1'b0;
        else
            wake_irq <= |(wake_stat_r | det_fire);
    end

    // link power state tracking
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            link_r <= ucpsm_pkg::LINK_L3;
        else
        begin
            unique case (link_r)
                ucpsm_pkg::LINK_L3:
                    // connection only counts with the controller enabled
                    if (conn_evt && ctrl_r[ucpsm_pkg::CTRL_USB_EN])
                        link_r <= ucpsm_pkg::LINK_L0;
                ucpsm_pkg::LINK_L0:
                begin
                    // disconnect first, then suspend, then lpm; toggles ignored
                    if (disc_evt)
                        link_r <= ucpsm_pkg::LINK_L3;
                    else if (ctl_suspend_evt)
                        link_r <= ucpsm_pkg::LINK_L2;
                    else if (link_power_ack_flag)
                        link_r <= ucpsm_pkg::LINK_L1;
                end
                ucpsm_pkg::LINK_L1,
                ucpsm_pkg::LINK_L2:
                begin
                    // both sleep states answer the same wake events
                    if (disc_evt)
                        link_r <= ucpsm_pkg::LINK_L3;
                    else if (resume_evt)
                        link_r <= ucpsm_pkg::LINK_L0;
                end
            endcase
        end
    end

    // usb clocks wanted only in L0
    assign want_on = (link_r == ucpsm_pkg::LINK_L0);

    // clock sequencer: one step at a time, a settle gap around each switch
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            seq_r     <= ucpsm_pkg::SEQ_IDLE;
            cnt_r     <= '0;
            lpm_off_r <= 1'b0;
            clk_ctl   <= '{xtal_en: 1'b0, sys_pll_en: 1'b0, sys_sel_32: 1'b0,
                           usb_pll_en: 1'b0, usb_pll_n: ucpsm_pkg::PLL_N_RST,
                           usb_pll_m: ucpsm_pkg::PLL_M_VALUE,
                           ctl_clk_en: 1'b0, phy_clk_en: 1'b0};
        end
        else
        begin
            unique case (seq_r)
                ucpsm_pkg::SEQ_IDLE:
                begin
                    // clocks off; start up on demand
                    if (want_on)
                    begin
                        clk_ctl.xtal_en <= 1'b1;
                        cnt_r           <= '0;
                        seq_r           <= clk_ctl.xtal_en ? ucpsm_pkg::SEQ_SYSTEM_PLL
                                                           : ucpsm_pkg::SEQ_XTAL;
                    end
                    else if (link_r == ucpsm_pkg::LINK_L3)
                    begin
                        // unplugged after lpm sleep: drop what the lpm variant kept
                        clk_ctl.usb_pll_en <= 1'b0;
                        clk_ctl.xtal_en    <= ctrl_r[ucpsm_pkg::CTRL_XTAL_KEEP];
                    end
                end
                ucpsm_pkg::SEQ_XTAL:
                begin
                    // crystal restart wait
                    if (cnt_r >= CNT_W'(XTAL_CYCLES - 1))
                        seq_r <= ucpsm_pkg::SEQ_SYSTEM_PLL;
                    else
                        cnt_r <= cnt_r + 1'b1;
                end
                ucpsm_pkg::SEQ_SYSTEM_PLL:
                begin
                    // system pll up and locked before switching
                    clk_ctl.sys_pll_en <= 1'b1;
                    cnt_r              <= '0;
                    if (clk_ctl.sys_pll_en && stable_r[ucpsm_pkg::NLINE])
                        seq_r <= ucpsm_pkg::SEQ_SYS32;
                end
                ucpsm_pkg::SEQ_SYS32:
                begin
                    // system to 32 MHz ahead of any usb pll start
                    clk_ctl.sys_sel_32 <= 1'b1;
                    if (cnt_r >= CNT_W'(ucpsm_pkg::SETTLE_CYC))
                    begin
                        cnt_r <= '0;
                        // usb pll kept running through lpm skips precharge and goes to the lock wait
                        if (clk_ctl.usb_pll_en)
                            seq_r <= ucpsm_pkg::SEQ_ULOCK;
                        else
                            seq_r <= ucpsm_pkg::SEQ_PRECH;
                    end
                    else
                        cnt_r <= cnt_r + 1'b1;
                end
                ucpsm_pkg::SEQ_PRECH:
                begin
                    // loop precharge with the wide divider
                    clk_ctl.usb_pll_en <= 1'b1;
                    clk_ctl.usb_pll_n  <= ucpsm_pkg::PLL_N_PRECHARGE;
                    clk_ctl.usb_pll_m  <= ucpsm_pkg::PLL_M_VALUE;
                    if (cnt_r >= CNT_W'(PRECHARGE_CYCLES - 1))
                    begin
                        cnt_r <= '0;
                        seq_r <= ucpsm_pkg::SEQ_ULOCK;
                    end
                    else
                        cnt_r <= cnt_r + 1'b1;
                end
                ucpsm_pkg::SEQ_ULOCK:
                begin
                    // target ratio, at least the restart time, then lock
                    clk_ctl.usb_pll_n <= ucpsm_pkg::PLL_N_TARGET;
                    if (cnt_r < CNT_W'(ucpsm_pkg::USB_PLL_RESTART_CYC))
                        cnt_r <= cnt_r + 1'b1;
                    else if (stable_r[ucpsm_pkg::NLINE + 1])
                    begin
                        cnt_r <= '0;
                        seq_r <= ucpsm_pkg::SEQ_GATE;
                    end
                end
                ucpsm_pkg::SEQ_GATE:
                begin
                    // both usb clocks ungated only on stable sources
                    clk_ctl.ctl_clk_en <= 1'b1;
                    clk_ctl.phy_clk_en <= 1'b1;
                    lpm_off_r          <= 1'b0;
                    seq_r              <= ucpsm_pkg::SEQ_ON;
                end
                ucpsm_pkg::SEQ_ON:
                begin
                    // running; leave when the link drops out of L0
                    if (!want_on)
                    begin
                        lpm_off_r <= (link_r == ucpsm_pkg::LINK_L1);
                        cnt_r     <= '0;
                        seq_r     <= ucpsm_pkg::SEQ_UNGATE;
                    end
                end
                ucpsm_pkg::SEQ_UNGATE:
                begin
                    // gate usb clocks before touching any source
                    clk_ctl.ctl_clk_en <= 1'b0;
                    clk_ctl.phy_clk_en <= 1'b0;
                    if (cnt_r >= CNT_W'(ucpsm_pkg::SETTLE_CYC))
                    begin
                        cnt_r <= '0;
                        seq_r <= ucpsm_pkg::SEQ_SYS16;
                    end
                    else
                        cnt_r <= cnt_r + 1'b1;
                end
                ucpsm_pkg::SEQ_SYS16:
                begin
                    // system back to 16 MHz before the plls stop
                    clk_ctl.sys_sel_32 <= 1'b0;
                    if (cnt_r >= CNT_W'(ucpsm_pkg::SETTLE_CYC))
                    begin
                        cnt_r <= '0;
                        seq_r <= ucpsm_pkg::SEQ_PLLOFF;
                    end
                    else
                        cnt_r <= cnt_r + 1'b1;
                end
                ucpsm_pkg::SEQ_PLLOFF:
                begin
                    // full shutdown, or lpm variant keeping the crystal
                    clk_ctl.sys_pll_en <= 1'b0;
                    if (!lpm_off_r || ctrl_r[ucpsm_pkg::CTRL_LPM_PLL_STOP])
                        clk_ctl.usb_pll_en <= 1'b0;
                    clk_ctl.xtal_en <= lpm_off_r || ctrl_r[ucpsm_pkg::CTRL_XTAL_KEEP];
                    seq_r           <= ucpsm_pkg::SEQ_IDLE;
                end
                default:
                    seq_r <= ucpsm_pkg::SEQ_IDLE;
            endcase
        end
    end

    // read data one cycle after the read strobe, zero otherwise
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            reg_rdata <= '0;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                ucpsm_pkg::CTRL_OFS:      reg_rdata <= {29'h0, ctrl_r};
                ucpsm_pkg::WAKE_CFG_OFS:  reg_rdata <= {16'h0, wake_cfg_r};
                ucpsm_pkg::WAKE_EN_OFS:   reg_rdata <= {29'h0, wake_en_r};
                ucpsm_pkg::WAKE_STAT_OFS: reg_rdata <= {29'h0, wake_stat_r};
                ucpsm_pkg::STATUS_OFS:    reg_rdata <= {24'h0, stable_r[NSYNC-1],
                                                        clk_ctl.usb_pll_en,
                                                        clk_ctl.sys_sel_32,
                                                        seq_r != ucpsm_pkg::SEQ_IDLE &&
                                                        seq_r != ucpsm_pkg::SEQ_ON,
                                                        clk_ctl.ctl_clk_en,
                                                        clk_ctl.xtal_en,
                                                        2'(link_r)};
                default:                  reg_rdata <= '0;
            endcase
        end
        else
            reg_rdata <= '0;
    end

endmodule : ucpsm_top

// ### ucpsm_props.sv
// checker of the clock control outputs of the usb clock manager
// assumes it is bound to ucpsm_top and sees only its ports
`timescale 1ns/1ps
module ucpsm_props (
    input wire logic                         mclk,
    input wire logic                         resetn,
    input wire logic                         reg_rd,
    input wire logic [ucpsm_pkg::DATA_W-1:0] reg_rdata,
    input wire logic                         usb_pll_lock,
    input wire ucpsm_pkg::ucpsm_clk_t        clk_ctl
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    // fast system clock held through the settle gap after gating
    sequence gap_s;
        clk_ctl.sys_sel_32 [*4];
    endsequence
    gate_needs_pll_a: assert property (clk_ctl.ctl_clk_en |-> clk_ctl.usb_pll_en)
        else $error("controller clock on without usb pll");
    phy_ctl_pair_a: assert property (clk_ctl.ctl_clk_en == clk_ctl.phy_clk_en)
        else $error("controller and phy clock gates differ");
    fast_needs_system_pll_a: assert property (clk_ctl.sys_sel_32 |-> clk_ctl.sys_pll_en)
        else $error("32 MHz system clock without system pll");
    pll_needs_xtal_a: assert property (clk_ctl.usb_pll_en |-> clk_ctl.xtal_en)
        else $error("usb pll on without crystal");
    pll_start_order_a: assert property ($rose(clk_ctl.usb_pll_en) |-> clk_ctl.sys_sel_32 && clk_ctl.usb_pll_n == 6'h3F)
        else $error("usb pll started wrongly");
    m_divider_a: assert property (clk_ctl.usb_pll_m == 2'h2)
        else $error("usb pll m divider wrong");
    gate_after_lock_a: assert property ($rose(clk_ctl.ctl_clk_en) |-> usb_pll_lock && clk_ctl.usb_pll_n == 6'h0F)
        else $error("usb clocks gated on before lock");
    mux_settle_a: assert property ($fell(clk_ctl.ctl_clk_en) |-> gap_s)
        else $error("system mux switched inside settle gap");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside read answer cycle");
endmodule : ucpsm_props
bind ucpsm_top ucpsm_props ucpsm_props_i (.mclk(mclk), .resetn(resetn), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .usb_pll_lock(usb_pll_lock), .clk_ctl(clk_ctl));

// ### ucpsm_partner.sv
// model of the usb controller and bus lines beside the clock manager
// assumes pll lock follows each pll enable after LOCK_CYC cycles
`timescale 1ns/1ps
module ucpsm_partner #(
    parameter int LOCK_CYC = 8 // lock delay in cycles
) (
    input  wire logic                  mclk,
    input  wire ucpsm_pkg::ucpsm_clk_t clk_ctl,
    output logic                       bus_power_sense,
    output logic                       line_dp,
    output logic                       line_dm,
    output logic                       sys_pll_lock,
    output logic                       usb_pll_lock,
    output logic                       ctl_suspend_evt,
    output logic                       link_power_ack_flag
);
    int sys_cnt = 0; // cycles since system pll enable
    int usb_cnt = 0; // cycles since usb pll enable
    // bus idle at start: no power, full speed idle levels
    initial
    begin
        bus_power_sense = 1'b0;
        line_dp = 1'b1;
        line_dm = 1'b0;
        ctl_suspend_evt = 1'b0;
        link_power_ack_flag = 1'b0;
    end
    // lock drops at once when a pll is disabled
    always @(posedge mclk)
    begin
        sys_cnt <= clk_ctl.sys_pll_en ? sys_cnt + 1 : 0;
        usb_cnt <= clk_ctl.usb_pll_en ? usb_cnt + 1 : 0;
    end
    assign sys_pll_lock = clk_ctl.sys_pll_en && sys_cnt >= LOCK_CYC;
    assign usb_pll_lock = clk_ctl.usb_pll_en && usb_cnt >= LOCK_CYC;
    // one-cycle suspend or lpm acknowledge event
    task automatic pulse(input bit lpm);
        @(posedge mclk);
        ctl_suspend_evt <= !lpm;
        link_power_ack_flag <= lpm;
        @(posedge mclk);
        ctl_suspend_evt <= 1'b0;
        link_power_ack_flag <= 1'b0;
    endtask : pulse
    // resume or reset signalling on the plus line
    task automatic toggle_dp();
        @(posedge mclk);
        line_dp <= 1'b0;
        repeat (10) @(posedge mclk);
        line_dp <= 1'b1;
    endtask : toggle_dp
    // plug or unplug the cable
    task automatic power(input bit v);
        @(posedge mclk);
        bus_power_sense <= v;
    endtask : power
endmodule : ucpsm_partner

// ### testbench.sv
// self-checking bench of the usb clock manager through its register port
// assumes short precharge and crystal counts to keep the run brief
`timescale 1ns/1ps
module testbench;
    logic                        mclk;
    logic                        resetn;
    logic [7:0]                  reg_addr;
    logic [31:0]                 reg_wdata;
    logic                        reg_wr;
    logic                        reg_rd;
    logic [31:0]                 reg_rdata;
    logic                        wake_irq;
    ucpsm_pkg::ucpsm_clk_t       clk_ctl;
    logic                        vb, dp, dm, sl, ul, se, la;
    logic [31:0]                 v;
    int                          n_fail = 0;
    int                          n_compared = 0;
    int                          cycles = 0;
    ucpsm_top #(.PRECHARGE_CYCLES(20), .XTAL_CYCLES(10)) ucpsm_top_i (.mclk(mclk),
        .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_power_sense(vb), .line_dp(dp),
        .line_dm(dm), .sys_pll_lock(sl), .usb_pll_lock(ul), .ctl_suspend_evt(se),
        .link_power_ack_flag(la), .wake_irq(wake_irq), .clk_ctl(clk_ctl));
    ucpsm_partner ucpsm_partner_i (.mclk(mclk), .clk_ctl(clk_ctl), .bus_power_sense(vb),
        .line_dp(dp), .line_dm(dm), .sys_pll_lock(sl), .usb_pll_lock(ul),
        .ctl_suspend_evt(se), .link_power_ack_flag(la));
    always #5 mclk = ~mclk;
    // hang guard, a few enable walks fit well inside
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            n_fail = n_fail + 1;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
            n_fail++;
        if (got !== exp)
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    // read data is taken in the single answer cycle
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    // poll status until masked bits match
    task automatic wait_st(input logic [7:0] m, input logic [7:0] w);
        rd(8'h10);
        while ((v[7:0] & m) !== w)
            rd(8'h10);
        repeat (8) @(posedge mclk);
        rd(8'h10);
    endtask : wait_st
    initial
    begin
        mclk = 1'b0;
        resetn = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        cmp({18'h0, clk_ctl}, 32'h0000_00F8);
        rd(8'h10);
        cmp(v, 32'h0000_0003);
        rd(8'h20);
        cmp(v, 32'h0);
        wr(8'h04, 32'h0000_B0A0);
        wr(8'h08, 32'h0000_0005);
        wr(8'h00, 32'h0000_0001);
        ucpsm_partner_i.power(1'b1);
        wait_st(8'h18, 8'h08);
        cmp(v, 32'h0000_00EC);
        cmp({31'h0, wake_irq}, 32'h1);
        rd(8'h0C);
        cmp(v, 32'h0000_0001);
        wr(8'h04, 32'h0000_C0A0);
        wr(8'h0C, 32'h0000_0007);
        rd(8'h0C);
        cmp(v, 32'h0);
        ucpsm_partner_i.toggle_dp();
        repeat (30) @(posedge mclk);
        rd(8'h10);
        cmp(v, 32'h0000_00EC);
        wr(8'h0C, 32'h0000_0007);
        ucpsm_partner_i.pulse(1'b0);
        wait_st(8'h18, 8'h00);
        cmp(v, 32'h0000_0002);
        ucpsm_partner_i.toggle_dp();
        wait_st(8'h18, 8'h08);
        cmp(v, 32'h0000_00EC);
        wr(8'h00, 32'h0000_0003);
        ucpsm_partner_i.pulse(1'b1);
        wait_st(8'h18, 8'h00);
        cmp(v, 32'h0000_0005);
        ucpsm_partner_i.toggle_dp();
        wait_st(8'h18, 8'h08);
        cmp(v, 32'h0000_00EC);
        wr(8'h00, 32'h0000_0001);
        ucpsm_partner_i.pulse(1'b1);
        wait_st(8'h18, 8'h00);
        cmp(v, 32'h0000_00C5);
        ucpsm_partner_i.power(1'b0);
        wait_st(8'h03, 8'h03);
        repeat (40) @(posedge mclk);
        rd(8'h10);
        cmp(v, 32'h0000_0003);
        report_and_stop();
    end
endmodule : testbench
